/* File: chroma_pkg.sv */
package chroma_pkg;
   // Sub-sampling formats of the stream.
   typedef enum logic [1:0] {
      FMT_444 = 2'h0,
      FMT_422 = 2'h1,
      FMT_420 = 2'h2
   } format_t;

   // Resampling methods.
   typedef enum logic [1:0] {
      METH_PROG = 2'h0,
      METH_FIXED = 2'h1,
      METH_REPL = 2'h2
   } method_t;

   localparam int DATA_W = 12;
   localparam int TAP_MAX = 8;
   localparam int COEF_W = 10;
   localparam int COEF_FRAC = 8;
   localparam int NUM_H_TAPS_DEF = 4;
   localparam int NUM_V_TAPS_DEF = 2;
   localparam int FIFO_DEPTH = 4;

   // Latency figures: horizontal in clock cycles, vertical in lines.
   localparam int LAT_UP_FIXED = 8;
   localparam int LAT_UP_REPL = 7;
   localparam int LAT_UP_PROG_ADD = 4;
   localparam int LAT_DN_FIXED = 10;
   localparam int LAT_DN_DROP = 2;
   localparam int LAT_DN_PROG_ADD = 7;
   localparam int LAT_V_DEF_LINES = 1;
   localparam int LAT_CNT_W = 13;

   // Frame size limits in pixels.
   localparam int FRAME_MIN = 32;
   localparam int FRAME_MAX = 7680;

   // One video beat: three components plus markers.
   typedef struct packed {
      logic [DATA_W-1:0] luma;
      logic [DATA_W-1:0] chroma_b;
      logic [DATA_W-1:0] chroma_r;
      logic frame_start;
      logic line_end_marker;
   } pixel_t;

   // Run-time control, the optional control port flattened.
   typedef struct packed {
      format_t fmt_in;
      format_t fmt_out;
      method_t method;
      logic interlaced;
      logic field_odd;
   } control_t;
endpackage : chroma_pkg

/* File: chroma_fifo.sv */
`timescale 1ns/1ps
module chroma_fifo #(
   parameter int WIDTH = 38,
   parameter int DEPTH = 4
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic arst_n,
   // Fill side.
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side.
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic push;
   logic pop;

   // Full and empty come straight from the occupancy count.
   assign in_ready = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Storage is written only on an accepted push.
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   // Pointers wrap at the depth, which need not be a power of two.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : chroma_fifo

/* File: chroma_subsample_converter.sv */
// Notes on behaviour
// - All six format conversions are selectable.
// - Upsampling uses two-phase polyphase interpolation.
// - Downsampling low-pass filters before dropping chroma.
// - Programmable, fixed power-of-two, or replicate/drop.
// - Components are 8, 10 or 12 bits.
// - Frames from 32x32 to 7680x7680 pixels.
// - Progressive frames and interlaced fields handled.
// - One output pixel per input sample.
// - Without input, drain buffers then stop.
// - Output stalled, accept until buffers fill.
// - One sample in, one pixel out per cycle.
// - Ready low for latency after each line.
// - Ready low for vertical latency only after a line whose last beat starts a frame.
// - One line equals samples taken between line ends.
// - 422 to 444 latency 8 or 2*taps+4.
// - 422 to 444 replicate latency is seven.
// - 444 to 422 latency 10 or taps+7.
// - 444 to 422 drop latency is two.
// - Control inputs may change at run time.
`timescale 1ns/1ps
module chroma_subsample_converter #(
   parameter int COMP_W = 8,
   parameter int NUM_H_TAPS = chroma_pkg::NUM_H_TAPS_DEF,
   parameter int NUM_V_TAPS = chroma_pkg::NUM_V_TAPS_DEF
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic arst_n,
   // Run-time control and programmable coefficients.
   input wire chroma_pkg::control_t ctrl,
   input wire logic [chroma_pkg::COEF_W-1:0] coef [chroma_pkg::TAP_MAX],
   // Input video stream.
   input wire logic s_valid,
   output logic s_ready,
   input wire chroma_pkg::pixel_t s_pixel,
   // Output video stream.
   output logic m_valid,
   input wire logic m_ready,
   output chroma_pkg::pixel_t m_pixel,
   // Line width measured on the input, in pixels.
   output logic [chroma_pkg::LAT_CNT_W-1:0] line_pixels
);
   import chroma_pkg::*;

   // Clamp for the measured line time, so a runaway line cannot push it past
   // FRAME_MAX; the frame flush product can still wrap and come out short.
   localparam logic [LAT_CNT_W-1:0] LINE_LAT_MAX = LAT_CNT_W'(FRAME_MAX);

   // Flush sequencer states.
   typedef enum logic [2:0] {
      ST_RUN = 3'b001,
      ST_LINE = 3'b010,
      ST_FRAME = 3'b100
   } flush_t;

   flush_t state;
   control_t cfg;
   logic [LAT_CNT_W-1:0] flush_cnt;
   logic [LAT_CNT_W-1:0] line_cnt;
   logic [LAT_CNT_W-1:0] row_cnt;
   logic [LAT_CNT_W-1:0] h_lat;
   logic [LAT_CNT_W-1:0] v_lines;
   logic [DATA_W-1:0] hist_b [TAP_MAX];
   logic [DATA_W-1:0] hist_r [TAP_MAX];
   logic [DATA_W-1:0] line_b [FRAME_MAX];
   logic [DATA_W-1:0] line_r [FRAME_MAX];
   logic [LAT_CNT_W-1:0] col;
   logic phase;
   logic accept;
   logic fifo_ready;
   logic up_h;
   logic dn_h;
   logic up_v;
   logic dn_v;
   pixel_t next_pix;
   pixel_t proc_pix;
   logic proc_valid;

   // Fixed filter: taps of 1/4,1/2,1/4 as shifts; programmable: MAC.
   // The fixed taps cost no multipliers, which is why that method is the
   // cheap one; the programmable path trades area for a sharper response.
   // The result saturates at the configured component width, so a large
   // coefficient set clips instead of wrapping into dark chroma.
   function automatic logic [DATA_W-1:0] filt(
      input logic [DATA_W-1:0] h [TAP_MAX],
      input method_t m,
      input logic [COEF_W-1:0] c [TAP_MAX]
   );
      logic [DATA_W+COEF_W+3:0] acc;
      acc = '0;
      if (m == METH_FIXED) begin
         acc = ((DATA_W+COEF_W+4)'(h[0]) + ((DATA_W+COEF_W+4)'(h[1]) << 1)
            + (DATA_W+COEF_W+4)'(h[2])) >> 2;
      end else begin
         for (int i = 0; i < TAP_MAX; i++) begin
            if (i < NUM_H_TAPS) begin
               acc = acc + (DATA_W+COEF_W+4)'(h[i] * c[i]);
            end
         end
         acc = acc >> COEF_FRAC;
      end
      return (acc > (DATA_W+COEF_W+4)'({COMP_W{1'b1}})) ?
         DATA_W'({COMP_W{1'b1}}) : acc[DATA_W-1:0];
   endfunction : filt

   assign up_h = (cfg.fmt_in != FMT_444) && (cfg.fmt_out == FMT_444);
   assign dn_h = (cfg.fmt_in == FMT_444) && (cfg.fmt_out != FMT_444);
   assign up_v = (cfg.fmt_in == FMT_420) && (cfg.fmt_out != FMT_420);
   assign dn_v = (cfg.fmt_in != FMT_420) && (cfg.fmt_out == FMT_420);

   always_comb begin
      h_lat = LAT_CNT_W'(LAT_DN_DROP);
      if (up_h) begin
         case (cfg.method)
            METH_FIXED: h_lat = LAT_CNT_W'(LAT_UP_FIXED);
            METH_REPL: h_lat = LAT_CNT_W'(LAT_UP_REPL);
            default: h_lat = LAT_CNT_W'(2*NUM_H_TAPS + LAT_UP_PROG_ADD);
         endcase
      end else if (dn_h) begin
         case (cfg.method)
            METH_FIXED: h_lat = LAT_CNT_W'(LAT_DN_FIXED);
            METH_REPL: h_lat = LAT_CNT_W'(LAT_DN_DROP);
            default: h_lat = LAT_CNT_W'(NUM_H_TAPS + LAT_DN_PROG_ADD);
         endcase
      end
   end

   assign v_lines = (up_v || dn_v) ? ((cfg.method == METH_PROG) ?
      LAT_CNT_W'(NUM_V_TAPS) : LAT_CNT_W'(LAT_V_DEF_LINES)) : '0;

   // ready while running and the buffer has room
   // The stage register is a buffer slot of its own: a new sample may only
   // enter when that slot is empty or is being emptied into the FIFO in
   // the same cycle. Otherwise a beat held there while the FIFO is full
   // would be overwritten and lost, breaking the one-in one-out pairing.
   assign s_ready = (state == ST_RUN) && (!proc_valid || fifo_ready);
   assign accept = s_valid && s_ready;

   // control is sampled at frame start, and while idle at the start of any line.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         cfg <= '0;
      end else if (state == ST_RUN && !accept && col == '0) begin
         cfg <= ctrl;
      end else if (accept && s_pixel.frame_start) begin
         cfg <= ctrl;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         state <= ST_RUN;
         flush_cnt <= '0;
      end else begin
         case (state)
            ST_RUN: begin
               if (accept && s_pixel.line_end_marker) begin
                  state <= ST_LINE;
                  flush_cnt <= h_lat;
               end
            end
            ST_LINE: begin
               if (flush_cnt > LAT_CNT_W'(1)) begin
                  flush_cnt <= flush_cnt - 1'b1;
               end else if (row_cnt == '0 && v_lines != '0) begin
                  // a line of flush is one measured line time
                  state <= ST_FRAME;
                  // The product is cut to the counter width on purpose;
                  // the clamped line time times NUM_V_TAPS can still pass that width and wrap.
                  flush_cnt <= LAT_CNT_W'(line_cnt * v_lines);
               end else begin
                  state <= ST_RUN;
               end
            end
            ST_FRAME: begin
               if (flush_cnt > LAT_CNT_W'(1)) begin
                  flush_cnt <= flush_cnt - 1'b1;
               end else begin
                  state <= ST_RUN;
               end
            end
            default: state <= ST_RUN;
         endcase
      end
   end

   // line time counter between line ends, frame row tracking
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         line_cnt <= LAT_CNT_W'(FRAME_MIN);
         row_cnt <= '0;
         col <= '0;
         line_pixels <= '0;
      end else if (accept) begin
         if (s_pixel.line_end_marker) begin
            line_pixels <= col + 1'b1;
            line_cnt <= (col >= LINE_LAT_MAX) ? LINE_LAT_MAX : col + 1'b1;
            col <= '0;
            row_cnt <= row_cnt + 1'b1;
         end else begin
            col <= col + 1'b1;
         end
         if (s_pixel.frame_start) begin
            row_cnt <= '0;
         end
      end
   end

   // Chroma history for the horizontal filter taps.
   // The history is not cleared at a line end: the first taps of a new
   // line still see the previous line's tail, a known small edge effect.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         hist_b <= '{default: '0};
         hist_r <= '{default: '0};
         phase <= 1'b0;
      end else if (accept) begin
         hist_b[0] <= s_pixel.chroma_b;
         hist_r[0] <= s_pixel.chroma_r;
         for (int i = 1; i < TAP_MAX; i++) begin
            hist_b[i] <= hist_b[i-1];
            hist_r[i] <= hist_r[i-1];
         end
         phase <= s_pixel.line_end_marker ? 1'b0 : ~phase;
      end
   end

   // Previous line chroma for vertical filtering; fields alike.
   always_ff @(posedge clk_sys) begin
      if (accept) begin
         line_b[col] <= next_pix.chroma_b;
         line_r[col] <= next_pix.chroma_r;
      end
   end

   // resample one beat per accepted sample
   always_comb begin
      next_pix = s_pixel;
      if (up_h) begin
         // odd phase interpolated (METH_REPL repeats the previous sample), even phase passes through
         if (phase && cfg.method != METH_REPL) begin
            next_pix.chroma_b = filt(hist_b, cfg.method, coef);
            next_pix.chroma_r = filt(hist_r, cfg.method, coef);
         end else if (phase) begin
            next_pix.chroma_b = hist_b[0];
            next_pix.chroma_r = hist_r[0];
         end
      end else if (dn_h && cfg.method != METH_REPL) begin
         // low-pass before the decimating chroma slot
         next_pix.chroma_b = filt(hist_b, cfg.method, coef);
         next_pix.chroma_r = filt(hist_r, cfg.method, coef);
      end
      if ((up_v || dn_v) && row_cnt != '0 && cfg.method != METH_REPL) begin
         next_pix.chroma_b = DATA_W'(({1'b0, next_pix.chroma_b}
            + {1'b0, line_b[col]}) >> 1);
         next_pix.chroma_r = DATA_W'(({1'b0, next_pix.chroma_r}
            + {1'b0, line_r[col]}) >> 1);
      end
      // luma bits above the configured width read as zero
      next_pix.luma = s_pixel.luma & DATA_W'({COMP_W{1'b1}});
   end

   // Registered stage feeding the buffer.
   // A beat stays here while the FIFO is full, so nothing is dropped
   // under back-pressure; together the stage and the FIFO hold five beats.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         proc_valid <= 1'b0;
         proc_pix <= '0;
      end else begin
         proc_valid <= accept || (proc_valid && !fifo_ready);
         if (accept) begin
            proc_pix <= next_pix;
         end
      end
   end

   // buffer holds output until taken
   // The output side is fed only from FIFO flops, so the pixel and its
   // valid stay put for as long as the sink holds ready low.
   chroma_fifo #(
      .WIDTH($bits(pixel_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .in_valid(proc_valid),
      .in_ready(fifo_ready),
      .in_data(proc_pix),
      .out_valid(m_valid),
      .out_ready(m_ready),
      .out_data(m_pixel)
   );
endmodule : chroma_subsample_converter

/* File: chroma_chk.sv */
`timescale 1ns/1ps
module chroma_chk (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic arst_n,
   // Input stream.
   input wire logic s_valid,
   input wire logic s_ready,
   input wire chroma_pkg::pixel_t s_pixel,
   // Output stream.
   input wire logic m_valid,
   input wire logic m_ready,
   input wire chroma_pkg::pixel_t m_pixel
);
   import chroma_pkg::*;
   logic take;
   logic pop;
   logic [3:0] held;
   // Handshakes at both ends.
   assign take = s_valid && s_ready;
   assign pop = m_valid && m_ready;
   // Beats owed downstream; the stage register adds one to the FIFO.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         held <= 4'h0;
      end else begin
         held <= held + 4'(take) - 4'(pop);
      end
   end
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n);
   property p_hold_data;
      m_valid && !m_ready |=> $stable(m_pixel);
   endproperty
   a_hold_data: assert property (p_hold_data)
      else $error("output pixel changed while stalled");
   property p_hold_valid;
      m_valid && !m_ready |=> m_valid;
   endproperty
   a_hold_valid: assert property (p_hold_valid)
      else $error("output valid dropped while stalled");
   property p_flush;
      take && s_pixel.line_end_marker |=> !s_ready;
   endproperty
   a_flush: assert property (p_flush)
      else $error("input ready high right after line end");
   property p_answer;
      take |-> ##[1:3] m_valid;
   endproperty
   a_answer: assert property (p_answer)
      else $error("no output after a taken sample");
   property p_drain;
      (!take) [*3] ##0 !m_valid |=> !m_valid;
   endproperty
   a_drain: assert property (p_drain)
      else $error("output valid without buffered input");
   property p_owed;
      m_valid |-> held != 4'h0;
   endproperty
   a_owed: assert property (p_owed)
      else $error("more output beats than input samples");
   property p_full;
      held == 4'(FIFO_DEPTH + 1) && !m_ready |-> !s_ready;
   endproperty
   a_full: assert property (p_full)
      else $error("input accepted with buffers full");
   property p_flow;
      take && pop && held < 4'(FIFO_DEPTH) && !s_pixel.line_end_marker
         && !s_pixel.frame_start |=> s_ready;
   endproperty
   a_flow: assert property (p_flow)
      else $error("streaming throughput interrupted");
   c_line: cover property (take && s_pixel.line_end_marker);
   c_stall: cover property (m_valid && !m_ready);
   c_full: cover property (held == 4'(FIFO_DEPTH + 1));
endmodule : chroma_chk
bind chroma_subsample_converter chroma_chk u_chk (
   .clk_sys(clk_sys),
   .arst_n(arst_n),
   .s_valid(s_valid),
   .s_ready(s_ready),
   .s_pixel(s_pixel),
   .m_valid(m_valid),
   .m_ready(m_ready),
   .m_pixel(m_pixel)
);

/* File: chroma_sink.sv */
`timescale 1ns/1ps
module chroma_sink (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic arst_n,
   // Back-pressure request from the bench.
   input wire logic stall,
   // Stream from the converter.
   input wire logic m_valid,
   input wire chroma_pkg::pixel_t m_pixel,
   output logic m_ready
);
   import chroma_pkg::*;
   logic [12:0] got [$];
   // Ready moves off the sampling edge so no race with the design.
   always @(negedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         m_ready <= 1'b0;
      end else begin
         m_ready <= !stall;
      end
   end
   // Only the marker and luma are kept: chroma is resampled.
   always @(posedge clk_sys) begin
      if (arst_n && m_valid && m_ready) begin
         got.push_back({m_pixel.line_end_marker, m_pixel.luma});
      end
   end
endmodule : chroma_sink

/* File: chroma_subsample_converter_tb.sv */
`timescale 1ns/1ps
module chroma_subsample_converter_tb;
   import chroma_pkg::*;
   logic clk_sys = 1'b0;
   logic arst_n = 1'b0;
   logic s_valid = 1'b0;
   logic stall = 1'b0;
   control_t ctrl;
   logic [COEF_W-1:0] coef [TAP_MAX];
   pixel_t s_pixel;
   pixel_t m_pixel;
   logic s_ready;
   logic m_valid;
   logic m_ready;
   logic [LAT_CNT_W-1:0] line_pixels;
   logic [12:0] exp_q [$];
   int err_total = 0;
   int checks = 0;
   // Free-running system clock.
   always #20 clk_sys = ~clk_sys;
   chroma_subsample_converter uut (.clk_sys(clk_sys), .arst_n(arst_n),
      .ctrl(ctrl), .coef(coef), .s_valid(s_valid), .s_ready(s_ready),
      .s_pixel(s_pixel), .m_valid(m_valid), .m_ready(m_ready),
      .m_pixel(m_pixel), .line_pixels(line_pixels));
   chroma_sink u_sink (.clk_sys(clk_sys), .arst_n(arst_n), .stall(stall),
      .m_valid(m_valid), .m_pixel(m_pixel), .m_ready(m_ready));
   task check(string what, logic [15:0] seen, logic [15:0] want);
      checks++;
      if (seen !== want) begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", what, want, seen);
      end
   endtask : check
   task give_verdict();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : give_verdict
   // Present one beat and hold it until the edge that takes it.
   task send(logic [12:0] v, logic fs);
      pixel_t p;
      int n;
      p = '0;
      p.luma = v[11:0];
      p.chroma_b = v[11:0];
      p.chroma_r = 12'h0ff - v[11:0];
      p.frame_start = fs;
      p.line_end_marker = v[12];
      @(negedge clk_sys);
      s_valid <= 1'b1;
      s_pixel <= p;
      n = 0;
      #1;
      while (!s_ready && n < 400) begin
         @(negedge clk_sys);
         #1;
         n++;
      end
      check("send wait", 16'(n < 400), 16'h0001);
      @(posedge clk_sys);
      exp_q.push_back(v);
   endtask : send
   // Wait for the sink to catch up, then compare beat by beat.
   task drain_check();
      int n;
      n = 0;
      while (u_sink.got.size() != exp_q.size() && n < 600) begin
         @(posedge clk_sys);
         n++;
      end
      check("beats", 16'(u_sink.got.size()), 16'(exp_q.size()));
      foreach (exp_q[i]) begin
         if (i < u_sink.got.size()) begin
            check("beat", u_sink.got[i], exp_q[i]);
         end
      end
      exp_q.delete();
      u_sink.got.delete();
   endtask : drain_check
   // Every conversion and method on one minimum-width line.
   task t_conv();
      format_t fi [6] = '{FMT_444, FMT_444, FMT_422, FMT_422, FMT_420,
         FMT_420};
      format_t fo [6] = '{FMT_422, FMT_420, FMT_444, FMT_420, FMT_444,
         FMT_422};
      int lat [6][3] = '{'{NUM_H_TAPS_DEF + 7, 10, 2}, '{0, 0, 0},
         '{2 * NUM_H_TAPS_DEF + 4, 8, 7}, '{0, 0, 0}, '{0, 0, 0},
         '{0, 0, 0}};
      int n;
      for (int c = 0; c < 6; c++) begin
         for (int m = 0; m < 3; m++) begin
            @(negedge clk_sys);
            ctrl <= '{fi[c], fo[c], method_t'(m), 1'b0, 1'b0};
            for (int i = 0; i < FRAME_MIN; i++) begin
               send({i == FRAME_MIN - 1, 12'(8 * c + i)}, i == 0);
            end
            @(negedge clk_sys);
            s_valid <= 1'b0;
            n = 0;
            #1;
            while (!s_ready && n < 300) begin
               @(negedge clk_sys);
               #1;
               n++;
            end
            check("flush ends", 16'(n < 300), 16'h0001);
            if (lat[c][m] != 0) begin
               check("flush", n >= lat[c][m] && n <= lat[c][m] + 1, 1);
            end
            check("width", line_pixels, 16'h0020);
            drain_check();
         end
      end
      $display("t_conv done");
   endtask : t_conv
   // Sink stalls: five beats fit, the sixth waits, then all drain.
   task t_stall();
      @(negedge clk_sys);
      stall <= 1'b1;
      for (int i = 0; i < FIFO_DEPTH + 1; i++) begin
         send(13'(i + 16'h0040), 1'b0);
      end
      @(negedge clk_sys);
      s_pixel.luma <= 12'h0050;
      repeat (6) begin
         @(negedge clk_sys);
         check("ready when full", s_ready, 0);
      end
      stall <= 1'b0;
      send(13'h0050, 1'b0);
      @(negedge clk_sys);
      s_valid <= 1'b0;
      drain_check();
      repeat (4) @(posedge clk_sys);
      check("idle valid", m_valid, 0);
      $display("t_stall done");
   endtask : t_stall
   // Cuts a hang short well past the expected run time.
   initial begin
      #(40 * 60000);
      err_total++;
      give_verdict();
   end
   initial begin
      ctrl = '0;
      s_pixel = '0;
      for (int i = 0; i < TAP_MAX; i++) begin
         coef[i] = 10'h040;
      end
      repeat (4) @(posedge clk_sys);
      @(negedge clk_sys);
      arst_n = 1'b1;
      t_conv();
      t_stall();
      give_verdict();
   end
endmodule : chroma_subsample_converter_tb
